/* rtl/gpedge_pkg.sv */
// Package: widths, encodings and carriers for the edge-registered GPIO port
package gpedge_pkg;
   localparam int PORT_WIDTH   = 8;
   localparam int PORT_COUNT   = 5;
   localparam int SEL_WIDTH    = 3;
   localparam int LOGIC_BLOCKS = 4;
   localparam int LB_SEL_WIDTH = 2;
   localparam logic [PORT_WIDTH-1:0] DATA_OUT_RESET = 8'h00;
   localparam logic [PORT_WIDTH-1:0] IRQ_FLAG_RESET = 8'h00;
   localparam logic [PORT_WIDTH-1:0] ALL_ZERO       = 8'h00;

   // Array clock source choices
   typedef enum logic [1:0] {
      GPEDGE_CLK_DIVIDER = 2'h0,
      GPEDGE_CLK_PORT    = 2'h1,
      GPEDGE_CLK_DIRECT  = 2'h3,
      GPEDGE_CLK_SYNCED  = 2'h2
   } gpedge_clk_src_t;

   // Per-pin drive source
   typedef enum logic [1:0] {
      GPEDGE_PIN_GPIO    = 2'h0,
      GPEDGE_PIN_FIXED   = 2'h1,
      GPEDGE_PIN_FABRIC  = 2'h3,
      GPEDGE_PIN_EDGEREG = 2'h2
   } gpedge_pin_src_t;

   typedef struct packed {
      logic [PORT_WIDTH-1:0] level;
      logic [PORT_WIDTH-1:0] outEn;
   } gpedge_drive_t;

   typedef struct packed {
      logic                  portClkEn;
      logic [SEL_WIDTH-1:0]  portClkPin;
   } gpedge_edge_cfg_t;
endpackage

/* rtl/gpedge_port.sv */
// Edge-registered 8-bit GPIO port with pin multiplexer and interrupt flags
`timescale 1ns/1ps
module gpedge_port
   import gpedge_pkg::*;
(
   input  wire logic                             clock,
   input  wire logic                             arst_n,
   input  wire logic [PORT_WIDTH-1:0]            pinIn,
   output logic      [PORT_WIDTH-1:0]            pinOut,
   output logic      [PORT_WIDTH-1:0]            pinOutEn,
   input  wire logic                             dataWrite,
   input  wire logic [PORT_WIDTH-1:0]            dataWriteValue,
   output logic      [PORT_WIDTH-1:0]            dataOut,
   output logic      [PORT_WIDTH-1:0]            pinState,
   input  wire logic [PORT_WIDTH-1:0]            driveEnable,
   input  wire gpedge_pin_src_t [PORT_WIDTH-1:0] pinSource,
   input  wire gpedge_drive_t                    fixedDrive,
   input  wire gpedge_drive_t                    fabricDrive,
   input  wire gpedge_edge_cfg_t                 edgeCfg,
   input  wire gpedge_clk_src_t                  arrayClkSel,
   input  wire logic                             dividerTick,
   input  wire logic                             fabricClk,
   output logic                                  arrayClkEvent,
   output logic      [PORT_WIDTH-1:0]            edgeIn,
   output logic      [PORT_WIDTH-1:0]            fabricIn,
   input  wire logic [LB_SEL_WIDTH-1:0]          fabricInRoute,
   output logic      [LOGIC_BLOCKS-1:0]          blockSelect,
   input  wire logic [PORT_WIDTH-1:0]            irqEnable,
   input  wire logic [PORT_WIDTH-1:0]            irqClear,
   output logic      [PORT_WIDTH-1:0]            irqFlags,
   output logic                                  portIrq,
   input  wire logic [LOGIC_BLOCKS-1:0]          blockIrqReq,
   input  wire logic [LB_SEL_WIDTH-1:0]          blockIrqOwner,
   output logic                                  blockIrq
);
   // Array clock is a qualifying event in this single-clock model
   logic [PORT_WIDTH-1:0] sync1_reg, sync2_reg, sync3_reg;
   logic [PORT_WIDTH-1:0] dataOut_reg, dataOut_next;
   logic [PORT_WIDTH-1:0] edgeIn_reg, edgeIn_next, edgeOut_reg, edgeOut_next;
   logic [PORT_WIDTH-1:0] flags_reg, flags_next;
   logic [PORT_WIDTH-1:0] pinOut_reg, pinOut_next, pinOutEn_reg, pinOutEn_next;
   logic [PORT_WIDTH-1:0] fabricIn_reg, fabricIn_next;
   logic [LOGIC_BLOCKS-1:0] blockSel_reg, blockSel_next;
   logic                  fabSync1_reg, fabSync2_reg, fabSync3_reg;
   logic                  pinClkPrev_reg, arrayEv_reg, arrayEv_next;
   logic                  portIrq_reg, portIrq_next, blockIrq_reg, blockIrq_next;
   logic                  pinClkLevel, pinClkRise, fabricRise, edgeEvent;

   // Two-stage synchronisers; third stage only for edge detection
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         sync1_reg    <= ALL_ZERO;
         sync2_reg    <= ALL_ZERO;
         sync3_reg    <= ALL_ZERO;
         fabSync1_reg <= 1'b0;
         fabSync2_reg <= 1'b0;
         fabSync3_reg <= 1'b0;
      end else begin
         sync1_reg    <= pinIn;
         sync2_reg    <= sync1_reg;
         sync3_reg    <= sync2_reg;
         fabSync1_reg <= fabricClk;
         fabSync2_reg <= fabSync1_reg;
         fabSync3_reg <= fabSync2_reg;
      end
   end

   always_comb begin
      pinClkLevel = sync2_reg[edgeCfg.portClkPin];
      pinClkRise  = pinClkLevel & ~pinClkPrev_reg;
      fabricRise  = fabSync2_reg & ~fabSync3_reg;
      // Direct fabric clock is sampled raw: faster, but the user owns its timing
      case (arrayClkSel)
         GPEDGE_CLK_DIVIDER: arrayEv_next = dividerTick;
         GPEDGE_CLK_PORT:    arrayEv_next = pinClkRise;
         GPEDGE_CLK_DIRECT:  arrayEv_next = fabricClk;
         GPEDGE_CLK_SYNCED:  arrayEv_next = fabricRise;
         default:            arrayEv_next = 1'b0;
      endcase
      // Pin clock skips the fabric hop, so edge stage catches inputs sooner
      edgeEvent = edgeCfg.portClkEn ? pinClkRise : arrayEv_reg;
   end

   always_comb begin
      dataOut_next  = dataWrite ? dataWriteValue : dataOut_reg;
      edgeIn_next   = edgeEvent ? sync2_reg : edgeIn_reg;
      edgeOut_next  = edgeEvent ? fabricDrive.level : edgeOut_reg;
      // Set wins over clear so no event is lost
      flags_next    = (flags_reg & ~irqClear) | (sync2_reg ^ sync3_reg);
      portIrq_next  = |(flags_next & irqEnable);
      fabricIn_next = sync2_reg;
      blockSel_next = LOGIC_BLOCKS'(1) << fabricInRoute;
      blockIrq_next = blockIrqReq[blockIrqOwner];
   end

   generate
      for (genvar i = 0; i < PORT_WIDTH; i++) begin : g_pin
         always_comb begin
            case (pinSource[i])
               GPEDGE_PIN_GPIO: begin
                  pinOut_next[i]   = dataOut_reg[i];
                  pinOutEn_next[i] = driveEnable[i];
               end
               GPEDGE_PIN_FIXED: begin
                  pinOut_next[i]   = fixedDrive.level[i];
                  pinOutEn_next[i] = fixedDrive.outEn[i];
               end
               GPEDGE_PIN_FABRIC: begin
                  pinOut_next[i]   = fabricDrive.level[i];
                  pinOutEn_next[i] = fabricDrive.outEn[i];
               end
               GPEDGE_PIN_EDGEREG: begin
                  pinOut_next[i]   = edgeOut_reg[i];
                  pinOutEn_next[i] = fabricDrive.outEn[i];
               end
               default: begin
                  pinOut_next[i]   = 1'b0;
                  pinOutEn_next[i] = 1'b0;
               end
            endcase
         end
      end
   endgenerate

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         dataOut_reg    <= DATA_OUT_RESET;
         edgeIn_reg     <= ALL_ZERO;
         edgeOut_reg    <= ALL_ZERO;
         flags_reg      <= IRQ_FLAG_RESET;
         pinOut_reg     <= ALL_ZERO;
         pinOutEn_reg   <= ALL_ZERO;
         fabricIn_reg   <= ALL_ZERO;
         blockSel_reg   <= '0;
         pinClkPrev_reg <= 1'b0;
         arrayEv_reg    <= 1'b0;
         portIrq_reg    <= 1'b0;
         blockIrq_reg   <= 1'b0;
      end else begin
         dataOut_reg    <= dataOut_next;
         edgeIn_reg     <= edgeIn_next;
         edgeOut_reg    <= edgeOut_next;
         flags_reg      <= flags_next;
         pinOut_reg     <= pinOut_next;
         pinOutEn_reg   <= pinOutEn_next;
         fabricIn_reg   <= fabricIn_next;
         blockSel_reg   <= blockSel_next;
         pinClkPrev_reg <= pinClkLevel;
         arrayEv_reg    <= arrayEv_next;
         portIrq_reg    <= portIrq_next;
         blockIrq_reg   <= blockIrq_next;
      end
   end

   assign pinOut        = pinOut_reg;
   assign pinOutEn      = pinOutEn_reg;
   assign dataOut       = dataOut_reg;
   assign pinState      = sync2_reg;
   assign edgeIn        = edgeIn_reg;
   assign fabricIn      = fabricIn_reg;
   assign blockSelect   = blockSel_reg;
   assign irqFlags      = flags_reg;
   assign portIrq       = portIrq_reg;
   assign blockIrq      = blockIrq_reg;
   assign arrayClkEvent = arrayEv_reg;

   property p_reset_off;
      @(posedge clock) !arst_n |=> pinOutEn == ALL_ZERO;
   endproperty
   a_reset_off: assert property (p_reset_off) else $error("pin driven after reset");

   property p_reset_state;
      @(posedge clock) !arst_n |=> dataOut == DATA_OUT_RESET && irqFlags == IRQ_FLAG_RESET && !portIrq;
   endproperty
   a_reset_state: assert property (p_reset_state) else $error("state kept through reset");

   property p_data_write;
      @(posedge clock) disable iff (!arst_n) dataWrite |=> dataOut == $past(dataWriteValue);
   endproperty
   a_data_write: assert property (p_data_write) else $error("data write lost");

   property p_data_hold;
      @(posedge clock) disable iff (!arst_n) (arst_n && !dataWrite) |=> $stable(dataOut);
   endproperty
   a_data_hold: assert property (p_data_hold) else $error("data register changed unasked");

   // Pipeline must be refilled after reset before the comparison means anything
   property p_pin_state;
      @(posedge clock) disable iff (!arst_n)
         ($past(arst_n) && $past(arst_n, 2)) |-> pinState == $past(pinIn, 2);
   endproperty
   a_pin_state: assert property (p_pin_state) else $error("pin state stale");

   property p_irq_gate;
      @(posedge clock) disable iff (!arst_n) portIrq == |(irqFlags & $past(irqEnable));
   endproperty
   a_irq_gate: assert property (p_irq_gate) else $error("port request wrong");

   property p_port_hold;
      @(posedge clock) disable iff (!arst_n)
         (|(irqFlags & irqEnable) && irqClear == ALL_ZERO) |=> portIrq;
   endproperty
   a_port_hold: assert property (p_port_hold) else $error("port request dropped");

   property p_irq_off;
      @(posedge clock) disable iff (!arst_n) (arst_n && irqEnable == ALL_ZERO) |=> !portIrq;
   endproperty
   a_irq_off: assert property (p_irq_off) else $error("request without enable");

   sequence s_flag_set;
      irqFlags[0] && !irqClear[0];
   endsequence
   property p_flag_hold;
      @(posedge clock) disable iff (!arst_n) s_flag_set |=> irqFlags[0];
   endproperty
   a_flag_hold: assert property (p_flag_hold) else $error("flag dropped");

   // One set of mux and flag checks per pin
   generate
      for (genvar j = 0; j < PORT_WIDTH; j++) begin : g_pin_chk
         property p_mux_gpio;
            @(posedge clock) disable iff (!arst_n)
               (arst_n && pinSource[j] == GPEDGE_PIN_GPIO)
               |=> pinOut[j] == $past(dataOut[j]) && pinOutEn[j] == $past(driveEnable[j]);
         endproperty
         a_mux_gpio: assert property (p_mux_gpio) else $error("gpio drive wrong");

         property p_mux_fixed;
            @(posedge clock) disable iff (!arst_n)
               (arst_n && pinSource[j] == GPEDGE_PIN_FIXED)
               |=> pinOut[j] == $past(fixedDrive.level[j]) && pinOutEn[j] == $past(fixedDrive.outEn[j]);
         endproperty
         a_mux_fixed: assert property (p_mux_fixed) else $error("fixed drive wrong");

         property p_mux_fabric;
            @(posedge clock) disable iff (!arst_n)
               (arst_n && pinSource[j] == GPEDGE_PIN_FABRIC)
               |=> pinOut[j] == $past(fabricDrive.level[j]) && pinOutEn[j] == $past(fabricDrive.outEn[j]);
         endproperty
         a_mux_fabric: assert property (p_mux_fabric) else $error("fabric drive wrong");

         property p_mux_edge;
            @(posedge clock) disable iff (!arst_n)
               (arst_n && pinSource[j] == GPEDGE_PIN_EDGEREG)
               |=> pinOutEn[j] == $past(fabricDrive.outEn[j]);
         endproperty
         a_mux_edge: assert property (p_mux_edge) else $error("edge drive enable wrong");

         sequence s_pin_toggle;
            sync2_reg[j] != sync3_reg[j];
         endsequence
         // Set wins over a clear in the same cycle
         property p_flag_set;
            @(posedge clock) disable iff (!arst_n) s_pin_toggle |=> irqFlags[j];
         endproperty
         a_flag_set: assert property (p_flag_set) else $error("pin event lost");

         property p_flag_clear;
            @(posedge clock) disable iff (!arst_n)
               (arst_n && irqClear[j] && sync2_reg[j] == sync3_reg[j]) |=> !irqFlags[j];
         endproperty
         a_flag_clear: assert property (p_flag_clear) else $error("flag not cleared");
      end
   endgenerate

   property p_edge_sample;
      @(posedge clock) disable iff (!arst_n)
         (!edgeCfg.portClkEn && arrayClkEvent) |=> edgeIn == $past(sync2_reg);
   endproperty
   a_edge_sample: assert property (p_edge_sample) else $error("edge stage missed");

   property p_pin_clock;
      @(posedge clock) disable iff (!arst_n)
         (edgeCfg.portClkEn && !pinClkRise) |=> $stable(edgeIn);
   endproperty
   a_pin_clock: assert property (p_pin_clock) else $error("edge stage off clock");

   property p_divider;
      @(posedge clock) disable iff (!arst_n)
         arrayClkSel == GPEDGE_CLK_DIVIDER |=> arrayClkEvent == $past(dividerTick);
   endproperty
   a_divider: assert property (p_divider) else $error("array clock source wrong");

   property p_direct;
      @(posedge clock) disable iff (!arst_n)
         (arst_n && arrayClkSel == GPEDGE_CLK_DIRECT) |=> arrayClkEvent == $past(fabricClk);
   endproperty
   a_direct: assert property (p_direct) else $error("direct fabric clock wrong");

   sequence s_fab_rise;
      fabSync2_reg && !fabSync3_reg;
   endsequence
   property p_synced;
      @(posedge clock) disable iff (!arst_n) (arrayClkSel == GPEDGE_CLK_SYNCED) ##0 s_fab_rise |=> arrayClkEvent;
   endproperty
   a_synced: assert property (p_synced) else $error("synced fabric clock missed");

   sequence s_pin_rise;
      pinClkRise;
   endsequence
   property p_port_clock;
      @(posedge clock) disable iff (!arst_n) (arrayClkSel == GPEDGE_CLK_PORT) ##0 s_pin_rise |=> arrayClkEvent;
   endproperty
   a_port_clock: assert property (p_port_clock) else $error("port clock missed");

   property p_block_sel;
      @(posedge clock) disable iff (!arst_n)
         arst_n |=> $onehot(blockSelect) && blockSelect[$past(fabricInRoute)];
   endproperty
   a_block_sel: assert property (p_block_sel) else $error("block route wrong");

   property p_fabric_in;
      @(posedge clock) disable iff (!arst_n) arst_n |=> fabricIn == $past(pinState);
   endproperty
   a_fabric_in: assert property (p_fabric_in) else $error("fabric input wrong");

   property p_block_irq;
      @(posedge clock) disable iff (!arst_n) $past(arst_n) |-> blockIrq == $past(blockIrqReq[blockIrqOwner]);
   endproperty
   a_block_irq: assert property (p_block_irq) else $error("block request wrong");
endmodule

/* verification/gpedge_pin_model.sv */
// Pin-side partner: external drivers with pull-up
`timescale 1ns/1ps
module gpedge_pin_model
   import gpedge_pkg::*;
(
   pinOut,
   pinOutEn,
   extDrive,
   extLevel,
   pinIn
);
   input  wire logic [PORT_WIDTH-1:0] pinOut;
   input  wire logic [PORT_WIDTH-1:0] pinOutEn;
   input  wire logic [PORT_WIDTH-1:0] extDrive;
   input  wire logic [PORT_WIDTH-1:0] extLevel;
   output logic      [PORT_WIDTH-1:0] pinIn;
   // Undriven pin floats to the pull-up, never holds old value
   always_comb begin
      for (int i = 0; i < PORT_WIDTH; i++) begin
         pinIn[i] = pinOutEn[i] ? pinOut[i] : (extDrive[i] ? extLevel[i] : 1'b1);
      end
   end
endmodule

/* verification/tb_top.sv */
// Self-checking bench for the edge-registered GPIO port
`timescale 1ns/1ps
module tb_top
   import gpedge_pkg::*;
;
   logic clock = 1'b0;
   logic arst_n = 1'b0;
   logic dataWrite, dividerTick, fabricClk, arrayClkEvent, portIrq, blockIrq;
   logic [7:0] pinIn, pinOut, pinOutEn, dataWriteValue, dataOut, pinState, driveEnable;
   logic [7:0] edgeIn, fabricIn, irqEnable, irqClear, irqFlags, extDrive, extLevel;
   logic [1:0] fabricInRoute, blockIrqOwner;
   logic [3:0] blockSelect, blockIrqReq;
   gpedge_pin_src_t [7:0] pinSource;
   gpedge_drive_t fixedDrive, fabricDrive;
   gpedge_edge_cfg_t edgeCfg;
   gpedge_clk_src_t arrayClkSel;
   int num_errors = 0;
   int n_tests = 0;
   always #25 clock = ~clock;
   gpedge_port u_gpedge_port (.clock, .arst_n, .pinIn, .pinOut, .pinOutEn, .dataWrite, .dataWriteValue,
      .dataOut, .pinState, .driveEnable, .pinSource, .fixedDrive, .fabricDrive, .edgeCfg, .arrayClkSel,
      .dividerTick, .fabricClk, .arrayClkEvent, .edgeIn, .fabricIn, .fabricInRoute, .blockSelect,
      .irqEnable, .irqClear, .irqFlags, .portIrq, .blockIrqReq, .blockIrqOwner, .blockIrq);
   gpedge_pin_model u_gpedge_pin_model (.pinOut, .pinOutEn, .extDrive, .extLevel, .pinIn);
   task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
      n_tests++;
      if (seen !== exp) begin
         num_errors++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic ticks(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask
   task automatic wrap_up;
      if (num_errors == 0 && n_tests > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic t_gpio;
      @(posedge clock);
      dataWrite <= 1'b1;
      dataWriteValue <= 8'hA5;
      @(posedge clock);
      dataWriteValue <= 8'h3C;
      #1 chk("dataOut", dataOut, 8'hA5);
      @(posedge clock);
      dataWrite <= 1'b0;
      #1 chk("pinOut", pinOut, 8'hA5);
      ticks(1);
      chk("pinOut2", pinOut, 8'h3C);
      chk("pinOutEn", pinOutEn, 8'hFF);
      ticks(3);
      chk("pinState", pinState, 8'h3C);
      arst_n = 1'b0;
      #1 chk("rstEn", pinOutEn, 8'h00);
      chk("rstData", dataOut, 8'h00);
      @(posedge clock);
      arst_n <= 1'b1;
   endtask
   task automatic t_mux;
      for (int k = 0; k < 2; k++) begin
         @(posedge clock);
         pinSource <= {8{k ? GPEDGE_PIN_FABRIC : GPEDGE_PIN_FIXED}};
         ticks(2);
         chk("muxEn", pinOutEn, k ? 8'h0F : 8'hF0);
         chk("muxLvl", pinOut & pinOutEn, k ? 8'h09 : 8'h90);
      end
      @(posedge clock);
      fabricDrive <= '{level: 8'hA5, outEn: 8'h7F};
      pinSource <= {8{GPEDGE_PIN_EDGEREG}};
      dividerTick <= 1'b1;
      @(posedge clock);
      dividerTick <= 1'b0;
      @(posedge clock);
      fabricDrive.level <= 8'h5A;
      ticks(5);
      chk("edgeHold", pinOut & pinOutEn, 8'h25);
      @(posedge clock);
      edgeCfg <= '{portClkEn: 1'b1, portClkPin: 3'h7};
      extLevel[7] <= 1'b0;
      ticks(3);
      @(posedge clock);
      extLevel[7] <= 1'b1;
      ticks(5);
      chk("pinClk", pinOut & pinOutEn, 8'h5A);
      chk("edgeIn", edgeIn, 8'hA5);
   endtask
   task automatic t_arrclk;
      int seen;
      for (int k = 0; k < 4; k++) begin
         @(posedge clock);
         arrayClkSel <= (k == 3) ? GPEDGE_CLK_DIRECT : (k == 2) ? GPEDGE_CLK_SYNCED : GPEDGE_CLK_DIVIDER;
         dividerTick <= (k == 0);
         fabricClk <= (k != 0);
         seen = 0;
         repeat (6) begin
            @(posedge clock);
            dividerTick <= 1'b0;
            #1 seen += int'(arrayClkEvent);
         end
         @(posedge clock);
         fabricClk <= 1'b0;
         chk("clkEvents", 8'(seen), (k == 1) ? 8'h00 : (k == 3) ? 8'h06 : 8'h01);
      end
   endtask
   task automatic t_irq;
      @(posedge clock);
      irqEnable <= 8'h01;
      irqClear <= 8'hFF;
      fabricDrive.outEn <= 8'h7C;
      ticks(6);
      @(posedge clock);
      irqClear <= 8'h00;
      extLevel[1:0] <= 2'b11;
      ticks(5);
      chk("flags", irqFlags, 8'h03);
      chk("portIrq", {7'h00, portIrq}, 8'h01);
      @(posedge clock);
      irqClear <= 8'h01;
      @(posedge clock);
      irqClear <= 8'h00;
      ticks(2);
      chk("flags2", irqFlags, 8'h02);
      chk("portIrq2", {7'h00, portIrq}, 8'h00);
   endtask
   task automatic t_block;
      for (int k = 0; k < 4; k++) begin
         @(posedge clock);
         fabricInRoute <= 2'(k);
         blockIrqOwner <= 2'(k);
         blockIrqReq <= 4'h4;
         ticks(2);
         chk("blockSel", {4'h0, blockSelect}, 8'h01 << k);
         chk("blockIrq", {7'h00, blockIrq}, {7'h00, k == 2});
      end
      chk("fabricIn", fabricIn, pinIn);
   endtask
   initial begin
      {dataWrite, dividerTick, fabricClk} = 3'h0;
      {dataWriteValue, irqEnable, irqClear} = 24'h0;
      {fabricInRoute, blockIrqOwner, blockIrqReq} = 8'h0;
      driveEnable = 8'hFF;
      extDrive = 8'hFF;
      extLevel = 8'h80;
      pinSource = {8{GPEDGE_PIN_GPIO}};
      fixedDrive = '{level: 8'h96, outEn: 8'hF0};
      fabricDrive = '{level: 8'h69, outEn: 8'h0F};
      edgeCfg = '{portClkEn: 1'b0, portClkPin: 3'h0};
      arrayClkSel = GPEDGE_CLK_DIVIDER;
      #60 chk("resetEn", pinOutEn, 8'h00);
      repeat (2) @(posedge clock);
      arst_n <= 1'b1;
      ticks(1);
      t_gpio();
      t_mux();
      t_arrclk();
      t_irq();
      t_block();
      wrap_up();
   end
   initial begin
      #100000;
      num_errors++;
      wrap_up();
   end
endmodule
